// [core/dbh_core_debug.sv]
// Core debug halt logic: breakpoints, halt request, comms channel.
// Assumes core bus inputs are on clock_i; debugger pins are not.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Tagged fetch halts on reaching execute
// - Level halt request after current instruction
// - Acknowledge high throughout debug state
// - At least two breakpoint units
// - Halt on address, data, control match
// - Masked bits excluded from comparison
// - Each unit instruction or data kind
// - Control, status and comms channel registers
// - Debugger access only through test port
// - No halt without trigger or request
module dbh_core_debug #(
    parameter int unsigned NBP = 2 // Breakpoint units
) (
    input  wire logic                       clock_i,     // Core clock
    input  wire logic                       rst_i,       // Async reset
    input  wire logic                       fetch_i,     // Fetch cycle
    input  wire logic [dbh_pkg::DATA_W-1:0] fetch_addr_i, // Fetch address
    input  wire logic [dbh_pkg::DATA_W-1:0] fetch_data_i, // Fetched opcode
    input  wire logic                       ext_break_tag_in_i, // Tag
    input  wire logic                       pipe_adv_i,  // Pipeline step
    input  wire logic                       pipe_flush_i, // Pipe flush
    input  wire logic                       instr_done_i, // Exec complete
    input  wire logic                       dacc_i,      // Data access
    input  wire logic [dbh_pkg::DATA_W-1:0] dacc_addr_i, // Data address
    input  wire logic [dbh_pkg::DATA_W-1:0] dacc_data_i, // Data value
    input  wire logic [dbh_pkg::CTL_W-1:0]  dacc_ctl_i,  // Data control
    input  wire logic                       halt_request_in_i, // Pin
    input  wire logic                       tck_i,       // Debugger clock
    input  wire logic                       tms_i,       // Update select
    input  wire logic                       tdi_i,       // Serial in
    output logic                            tdo_o,       // Serial out
    input  wire logic                       psel_i,      // APB select
    input  wire logic                       penable_i,   // APB enable
    input  wire logic                       pwrite_i,    // APB write
    input  wire logic [7:0]                 paddr_i,     // APB address
    input  wire logic [dbh_pkg::DATA_W-1:0] pwdata_i,    // APB wdata
    output logic [dbh_pkg::DATA_W-1:0]      prdata_o,    // APB rdata
    output logic                            pready_o,    // APB ready
    output logic                            pslverr_o,   // APB error
    output logic                            halted_ack_out_o, // Halted
    output logic                            irq_o        // Interrupt
);
    import dbh_pkg::*;

    if (NBP < 2 || NBP > 7) begin : g_bad_nbp
        $error("NBP must be 2 to 7");
    end

    typedef struct packed {
        dbh_state_e state;
        logic hreq_s1, hreq_s2, ctl_halt;
        logic tag_f, tag_d, tag_x, dpend;
        logic cause_tag, cause_bp, cause_req;
        logic [NBP-1:0][DATA_W-1:0] aval, amsk, dval, dmsk;
        logic [NBP-1:0][BPC_W-1:0] bpc;
        logic [DATA_W-1:0] to_core, from_core;
        logic rx_full, tx_full;
        logic [IRQ_W-1:0] irq_stat, irq_mask;
        logic [DATA_W-1:0] prdata;
        logic pready, pslverr, irq, ack;
    } dbh_core_s;

    dbh_core_s q, n;

    logic [NBP-1:0]     hit;
    logic               ihit, dhit, halt_want, resume, acc;
    logic               sc_req, sc_wr;
    logic [SCAN_AW-1:0] sc_addr;
    logic [DATA_W-1:0]  sc_wdata, sc_rdata;
    logic [IRQ_W-1:0]   ev;
    logic [2:0]         sc_sel, sc_fld;

    function automatic logic [2:0] bp_sel(input logic [SCAN_AW-1:0] a);
        return 3'(a[SCAN_AW-1:BP_SEL_LSB] - 3'h1);
    endfunction

    function automatic logic is_bp(input logic [SCAN_AW-1:0] a);
        return a >= SC_BP_BASE && 32'(bp_sel(a)) < NBP;
    endfunction

    // ************************************************
    // Breakpoint units
    // ************************************************
    for (genvar i = 0; i < NBP; i++) begin : g_bp
        logic is_i;
        assign is_i = q.bpc[i][BPC_INSTR];
        dbh_bp_unit u_bp (
            .enable_i (q.bpc[i][BPC_EN]),
            .strobe_i (is_i ? fetch_i : dacc_i),
            .addr_i   (is_i ? fetch_addr_i : dacc_addr_i),
            .data_i   (is_i ? fetch_data_i : dacc_data_i),
            .ctl_i    (is_i ? '0 : dacc_ctl_i),
            .aval_i   (q.aval[i]),
            .amsk_i   (q.amsk[i]),
            .dval_i   (q.dval[i]),
            .dmsk_i   (q.dmsk[i]),
            .cval_i   (q.bpc[i][BPC_CVAL +: CTL_W]),
            .cmsk_i   (q.bpc[i][BPC_CMSK +: CTL_W]),
            .hit_o    (hit[i])
        );
    end

    dbh_scan_port u_scan (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .tck_i   (tck_i),
        .tms_i   (tms_i),
        .tdi_i   (tdi_i),
        .rdata_i (sc_rdata),
        .tdo_o   (tdo_o),
        .req_o   (sc_req),
        .wr_o    (sc_wr),
        .addr_o  (sc_addr),
        .wdata_o (sc_wdata)
    );

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        n = q;
        ihit = 1'b0;
        dhit = 1'b0;
        for (int i = 0; i < NBP; i++) begin
            ihit = ihit | (hit[i] & q.bpc[i][BPC_INSTR]);
            dhit = dhit | (hit[i] & ~q.bpc[i][BPC_INSTR]);
        end
        n.hreq_s1 = halt_request_in_i;
        n.hreq_s2 = q.hreq_s1;
        // control bit acts as the pin
        halt_want = q.hreq_s2 | q.ctl_halt;
        sc_sel = bp_sel(sc_addr);
        sc_fld = sc_addr[BP_SEL_LSB-1:BP_FLD_LSB];
        ev = '0;
        resume = 1'b0;

        sc_rdata = '0;
        if (sc_addr == SC_CTRL) begin
            sc_rdata[CTL_HALT] = q.ctl_halt;
        end else if (sc_addr == SC_STAT) begin
            sc_rdata[5:0] = {q.tx_full, q.rx_full, q.cause_req,
                             q.cause_bp, q.cause_tag, q.ack};
        end else if (sc_addr == SC_FROM_CORE) begin
            sc_rdata = q.from_core;
        end else if (is_bp(sc_addr)) begin
            unique case (sc_fld)
                BPF_AVAL: sc_rdata = q.aval[sc_sel];
                BPF_AMSK: sc_rdata = q.amsk[sc_sel];
                BPF_DVAL: sc_rdata = q.dval[sc_sel];
                BPF_DMSK: sc_rdata = q.dmsk[sc_sel];
                BPF_CTRL: sc_rdata[BPC_W-1:0] = q.bpc[sc_sel];
                default:  sc_rdata = '0;
            endcase
        end
        if (sc_req && sc_wr) begin
            if (sc_addr == SC_CTRL) begin
                n.ctl_halt = sc_wdata[CTL_HALT];
                resume = sc_wdata[CTL_RESUME] & (q.state == DBH_HALT);
            end else if (sc_addr == SC_TO_CORE) begin
                n.to_core = sc_wdata;
                n.rx_full = 1'b1;
                ev[IRQ_RX] = 1'b1;
            end else if (is_bp(sc_addr)) begin
                unique case (sc_fld)
                    BPF_AVAL: n.aval[sc_sel] = sc_wdata;
                    BPF_AMSK: n.amsk[sc_sel] = sc_wdata;
                    BPF_DVAL: n.dval[sc_sel] = sc_wdata;
                    BPF_DMSK: n.dmsk[sc_sel] = sc_wdata;
                    BPF_CTRL: n.bpc[sc_sel] = sc_wdata[BPC_W-1:0];
                    default:  n.ctl_halt = q.ctl_halt;
                endcase
            end
        end
        if (sc_req && !sc_wr && sc_addr == SC_FROM_CORE && q.tx_full) begin
            n.tx_full = 1'b0;
            ev[IRQ_TX] = 1'b1;
        end

        if (pipe_adv_i) begin
            n.tag_x = q.tag_d;
            n.tag_d = q.tag_f;
            n.tag_f = 1'b0;
        end
        if (fetch_i) begin
            n.tag_f = ext_break_tag_in_i | ihit;
        end
        if (pipe_flush_i) begin
            n.tag_f = 1'b0;
            n.tag_d = 1'b0;
            n.tag_x = 1'b0;
        end
        if (dhit) begin
            n.dpend = 1'b1;
        end

        // halt only on trigger or request
        unique case (q.state)
            DBH_RUN: begin
                if (q.tag_x) begin
                    n.state = DBH_HALT;
                    n.cause_tag = 1'b1;
                end else if (halt_want || q.dpend) begin
                    n.state = DBH_DRAIN;
                end
            end
            DBH_DRAIN: begin
                if (q.tag_x) begin
                    n.state = DBH_HALT;
                    n.cause_tag = 1'b1;
                end else if (instr_done_i && (halt_want || q.dpend)) begin
                    n.state = DBH_HALT;
                    n.cause_bp = q.dpend;
                    n.cause_req = halt_want;
                    n.dpend = 1'b0;
                end else if (!halt_want && !q.dpend) begin
                    n.state = DBH_RUN;
                end
            end
            DBH_HALT: begin
                if (resume) begin
                    n.state = DBH_RUN;
                    n.tag_x = 1'b0;
                    n.cause_tag = 1'b0;
                    n.cause_bp = 1'b0;
                    n.cause_req = 1'b0;
                    ev[IRQ_RESUME] = 1'b1;
                end
            end
            default: n.state = DBH_RUN;
        endcase
        n.ack = (n.state == DBH_HALT);

        // ************************************************
        // APB slave, one wait state
        // ************************************************
        acc = psel_i & penable_i & ~q.pready;
        n.pready = acc;
        n.pslverr = 1'b0;
        n.prdata = '0;
        if (acc) begin
            unique case (paddr_i)
                PA_DCC: begin
                    if (pwrite_i) begin
                        // Refused rather than lose unread data
                        n.pslverr = q.tx_full;
                        if (!q.tx_full) begin
                            n.from_core = pwdata_i;
                            n.tx_full = 1'b1;
                        end
                    end else begin
                        n.prdata = q.to_core;
                        n.rx_full = ev[IRQ_RX];
                    end
                end
                PA_IRQ_STAT: begin
                    n.prdata[IRQ_W-1:0] = q.irq_stat;
                    if (pwrite_i) begin
                        n.irq_stat = q.irq_stat & ~pwdata_i[IRQ_W-1:0];
                    end
                end
                PA_IRQ_MASK: begin
                    n.prdata[IRQ_W-1:0] = q.irq_mask;
                    if (pwrite_i) begin
                        n.irq_mask = pwdata_i[IRQ_W-1:0];
                    end
                end
                PA_STAT: n.prdata[2:0] = {q.ack, q.tx_full, q.rx_full};
                default: n.pslverr = 1'b1;
            endcase
        end
        // Set wins over a same-cycle clear
        n.irq_stat = n.irq_stat | ev;
        n.irq = |(n.irq_stat & n.irq_mask);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign prdata_o         = q.prdata;
    assign pready_o         = q.pready;
    assign pslverr_o        = q.pslverr;
    assign halted_ack_out_o = q.ack;
    assign irq_o            = q.irq;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_drain_done;
        q.state == DBH_DRAIN && !q.tag_x && instr_done_i && halt_want;
    endsequence

    property p_tag_halts;
        q.tag_x && q.state != DBH_HALT |=> halted_ack_out_o;
    endproperty
    a_tag_halts: assert property (p_tag_halts)
        else $error("tagged instruction reached execute without halt");

    property p_req_done;
        s_drain_done |=> halted_ack_out_o && q.cause_req;
    endproperty
    a_req_done: assert property (p_req_done)
        else $error("request not honoured at completion");

    property p_req_waits;
        q.state == DBH_RUN && !q.tag_x |=> !halted_ack_out_o;
    endproperty
    a_req_waits: assert property (p_req_waits)
        else $error("halted before the instruction completed");

    property p_ack_holds;
        halted_ack_out_o && !resume |=> halted_ack_out_o [*2] or
            (halted_ack_out_o ##1 !halted_ack_out_o);
    endproperty
    a_ack_holds: assert property (p_ack_holds)
        else $error("acknowledge dropped while halted");

    property p_ack_drop;
        resume |=> !halted_ack_out_o && q.irq_stat[IRQ_RESUME];
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("resume did not leave debug state");

    property p_data_hit;
        dhit && q.state == DBH_RUN |=> q.dpend ##1 q.state != DBH_RUN;
    endproperty
    a_data_hit: assert property (p_data_hit)
        else $error("data match did not start a halt");

    property p_inst_tag;
        fetch_i && ihit && !pipe_flush_i |=> q.tag_f;
    endproperty
    a_inst_tag: assert property (p_inst_tag)
        else $error("instruction match not tagged");

    property p_quiet;
        q.state == DBH_RUN && !q.tag_x && !q.dpend && !halt_want
            |=> q.state == DBH_RUN;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("left run state without cause");

    property p_dcc_rx;
        sc_req && sc_wr && sc_addr == SC_TO_CORE |=> q.rx_full ##1 q.irq_stat[IRQ_RX];
    endproperty
    a_dcc_rx: assert property (p_dcc_rx)
        else $error("comms word from debugger not flagged");

    property p_apb_one_wait;
        psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait)
        else $error("APB answer not one pulse after one wait");
endmodule
`default_nettype wire

// [inc/dbh_pkg.sv]
// Shared constants for the core debug halt block.
// Assumes a 32-bit core bus and an APB register bus.
package dbh_pkg;
    // ************************************************
    // Widths
    // ************************************************
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned CTL_W   = 2;
    localparam int unsigned SCAN_AW = 8;
    localparam int unsigned SCAN_W  = 1 + SCAN_AW + DATA_W;
    localparam int unsigned SC_A_LSB = 1;
    localparam int unsigned SC_D_LSB = 1 + SCAN_AW;
    localparam int unsigned BPC_W   = 10;
    localparam int unsigned IRQ_W   = 3;
    localparam int unsigned BP_SEL_LSB = 5;
    localparam int unsigned BP_FLD_LSB = 2;
    // ************************************************
    // Scan-port register map (debugger side)
    // ************************************************
    localparam logic [7:0] SC_CTRL      = 8'h00;
    localparam logic [7:0] SC_STAT      = 8'h04;
    localparam logic [7:0] SC_TO_CORE   = 8'h08;
    localparam logic [7:0] SC_FROM_CORE = 8'h0C;
    localparam logic [7:0] SC_BP_BASE   = 8'h20;
    localparam logic [2:0] BPF_AVAL = 3'h0;
    localparam logic [2:0] BPF_AMSK = 3'h1;
    localparam logic [2:0] BPF_DVAL = 3'h2;
    localparam logic [2:0] BPF_DMSK = 3'h3;
    localparam logic [2:0] BPF_CTRL = 3'h4;
    localparam int unsigned CTL_HALT   = 0;
    localparam int unsigned CTL_RESUME = 1;
    localparam int unsigned BPC_EN    = 0;
    localparam int unsigned BPC_INSTR = 1;
    localparam int unsigned BPC_CVAL  = 4;
    localparam int unsigned BPC_CMSK  = 8;
    // ************************************************
    // APB register map (core software side)
    // ************************************************
    localparam logic [7:0] PA_DCC      = 8'h00;
    localparam logic [7:0] PA_IRQ_STAT = 8'h04;
    localparam logic [7:0] PA_IRQ_MASK = 8'h08;
    localparam logic [7:0] PA_STAT     = 8'h0C;
    localparam int unsigned IRQ_RX     = 0;
    localparam int unsigned IRQ_TX     = 1;
    localparam int unsigned IRQ_RESUME = 2;
    typedef enum logic [1:0] {
        DBH_RUN   = 2'b00,
        DBH_DRAIN = 2'b01,
        DBH_HALT  = 2'b11
    } dbh_state_e;
endpackage

// [core/dbh_bp_unit.sv]
// One breakpoint comparator with per-bit masks.
// Assumes bus inputs are already selected for its kind.
`timescale 1ns/1ps
`default_nettype none
module dbh_bp_unit (
    input  wire logic                       enable_i, // Unit armed
    input  wire logic                       strobe_i, // Bus cycle valid
    input  wire logic [dbh_pkg::DATA_W-1:0] addr_i,   // Bus address
    input  wire logic [dbh_pkg::DATA_W-1:0] data_i,   // Bus data
    input  wire logic [dbh_pkg::CTL_W-1:0]  ctl_i,    // Bus control
    input  wire logic [dbh_pkg::DATA_W-1:0] aval_i,   // Address value
    input  wire logic [dbh_pkg::DATA_W-1:0] amsk_i,   // Address mask
    input  wire logic [dbh_pkg::DATA_W-1:0] dval_i,   // Data value
    input  wire logic [dbh_pkg::DATA_W-1:0] dmsk_i,   // Data mask
    input  wire logic [dbh_pkg::CTL_W-1:0]  cval_i,   // Control value
    input  wire logic [dbh_pkg::CTL_W-1:0]  cmsk_i,   // Control mask
    output logic                            hit_o     // Match this cycle
);
    import dbh_pkg::*;

    // Mask bit set means the bit is left out
    function automatic logic masked_eq(input logic [DATA_W-1:0] a,
                                       input logic [DATA_W-1:0] b,
                                       input logic [DATA_W-1:0] m);
        return ((a ^ b) & ~m) == '0;
    endfunction

    localparam int unsigned PADW = DATA_W - CTL_W;

    always_comb begin
        hit_o = enable_i & strobe_i
              & masked_eq(addr_i, aval_i, amsk_i)
              & masked_eq(data_i, dval_i, dmsk_i)
              & masked_eq({{PADW{1'b0}}, ctl_i},
                          {{PADW{1'b0}}, cval_i},
                          {{PADW{1'b0}}, cmsk_i});
    end
endmodule
`default_nettype wire

// [core/dbh_scan_port.sv]
// Serial debugger access port, sampled on the core clock.
// Assumes the debugger clock is much slower than clock_i.
`timescale 1ns/1ps
`default_nettype none
module dbh_scan_port (
    input  wire logic                        clock_i, // Core clock
    input  wire logic                        rst_i,   // Async reset
    input  wire logic                        tck_i,   // Debugger clock pin
    input  wire logic                        tms_i,   // Update select pin
    input  wire logic                        tdi_i,   // Serial data in
    input  wire logic [dbh_pkg::DATA_W-1:0]  rdata_i, // Read data
    output logic                             tdo_o,   // Serial data out
    output logic                             req_o,   // Access pulse
    output logic                             wr_o,    // Access is write
    output logic [dbh_pkg::SCAN_AW-1:0]      addr_o,  // Access address
    output logic [dbh_pkg::DATA_W-1:0]       wdata_o  // Write data
);
    import dbh_pkg::*;

    typedef struct packed {
        logic tck_s1, tck_s2, tck_s3;
        logic tms_s1, tms_s2, tdi_s1, tdi_s2;
        logic [SCAN_W-1:0] sr;
        logic tdo, req, wr;
        logic [SCAN_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dbh_scan_s;

    dbh_scan_s q, n;
    logic      tck_rise;

    always_comb begin
        n = q;
        n.tck_s1 = tck_i;
        n.tck_s2 = q.tck_s1;
        n.tck_s3 = q.tck_s2;
        n.tms_s1 = tms_i;
        n.tms_s2 = q.tms_s1;
        n.tdi_s1 = tdi_i;
        n.tdi_s2 = q.tdi_s1;
        n.req = 1'b0;
        tck_rise = q.tck_s2 & ~q.tck_s3;
        // Read data lands one cycle after the access pulse
        if (q.req) begin
            n.sr[SCAN_W-1:SC_D_LSB] = rdata_i;
        end
        if (tck_rise) begin
            if (q.tms_s2) begin
                n.req   = 1'b1;
                n.wr    = q.sr[0];
                n.addr  = q.sr[SC_D_LSB-1:SC_A_LSB];
                n.wdata = q.sr[SCAN_W-1:SC_D_LSB];
            end else begin
                n.sr = {q.tdi_s2, q.sr[SCAN_W-1:1]};
            end
        end
        n.tdo = n.sr[0];
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tdo_o   = q.tdo;
    assign req_o   = q.req;
    assign wr_o    = q.wr;
    assign addr_o  = q.addr;
    assign wdata_o = q.wdata;

    property p_req_from_edge;
        @(posedge clock_i) disable iff (rst_i)
        req_o |-> $past(tck_rise) && $past(q.tms_s2) && !$past(req_o);
    endproperty
    a_req_from_edge: assert property (p_req_from_edge)
        else $error("access pulse without update edge");
endmodule
`default_nettype wire

// [test/dbh_probe.sv]
// Debugger probe model for the serial access port.
// Assumes the block samples tck on clock_i; tck idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module dbh_probe (
    input  wire logic clock_i, // Core clock
    input  wire logic tdo_i,   // Serial data from block
    output logic      tck_o,   // Debugger clock
    output logic      tms_o,   // Update select
    output logic      tdi_o    // Serial data to block
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b0;
        tdi_o = 1'b0;
    end
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [40:0] q);
        logic [40:0] w;
        w = {d, a, wr};
        for (int i = 0; i < 42; i++) begin
            @(posedge clock_i);
            tms_o <= (i == 41);
            tdi_o <= (i < 41) ? w[i] : ~w[40];
            // Four low and four high core cycles give a 200 ns link clock
            repeat (3) @(posedge clock_i);
            if (i < 41) q[i] = tdo_i;
            tck_o <= 1'b1;
            repeat (4) @(posedge clock_i);
            tck_o <= 1'b0;
        end
        // Let read data load before the next frame shifts it out
        repeat (8) @(posedge clock_i);
        tms_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [test/dbh_core_debug_tb.sv]
// Self-checking bench for the core debug halt block.
// Assumes dbh_probe stands for the debugger on the serial port.
`timescale 1ns/1ps
`default_nettype none
module dbh_core_debug_tb;
    import dbh_pkg::*;
    logic clock_i, rst_i, fetch_i, ext_break_tag_in_i, pipe_adv_i, pipe_flush_i, instr_done_i;
    logic dacc_i, halt_request_in_i, tck_i, tms_i, tdi_i, tdo_o, psel_i, penable_i, pwrite_i;
    logic pready_o, pslverr_o, halted_ack_out_o, irq_o, e;
    logic [7:0] paddr_i, b;
    logic [1:0] dacc_ctl_i;
    logic [31:0] fetch_addr_i, fetch_data_i, dacc_addr_i, dacc_data_i, pwdata_i, prdata_o, s, r, v, m, x;
    logic [40:0] q;
    int failures, samples_checked;
    dbh_core_debug u_dbh_core_debug (.*);
    dbh_probe u_dbh_probe (.clock_i(clock_i), .tdo_i(tdo_o), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i));
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    function automatic logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic hit(input logic [31:0] val, msk, a);
        return ((val ^ a) & ~msk) == 32'h0;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge clock_i);
        penable_i <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clock_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask
    task automatic sw(input logic [7:0] a, input logic [31:0] d);
        u_dbh_probe.access(1'b1, a, d, q);
    endtask
    task automatic step(input int k);
        @(posedge clock_i);
        if (k == 0) pipe_adv_i <= 1'b1;
        else instr_done_i <= 1'b1;
        @(posedge clock_i);
        {pipe_adv_i, instr_done_i} <= 2'b00;
    endtask
    task automatic fire(input logic tg, fl, input logic [31:0] a);
        @(posedge clock_i);
        {fetch_i, ext_break_tag_in_i, fetch_addr_i, fetch_data_i} <= {1'b1, tg, a, xs()};
        @(posedge clock_i);
        {fetch_i, ext_break_tag_in_i, pipe_flush_i} <= {2'b00, fl};
        @(posedge clock_i);
        pipe_flush_i <= 1'b0;
        step(0);
        step(0);
        repeat (4) @(posedge clock_i);
    endtask
    task automatic resume();
        sw(SC_CTRL, 32'h2);
        chk("ack after resume", halted_ack_out_o, 0);
    endtask
    initial begin
        #2000000;
        failures++;
        wrap_up();
    end
    initial begin
        {fetch_i, ext_break_tag_in_i, pipe_adv_i, pipe_flush_i, instr_done_i, dacc_i} = '0;
        {halt_request_in_i, psel_i, penable_i, pwrite_i, paddr_i, dacc_ctl_i} = '0;
        {fetch_addr_i, fetch_data_i, dacc_addr_i, dacc_data_i, pwdata_i} = '0;
        s = 32'h59ED;
        rst_i = 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk("ack after reset", halted_ack_out_o, 0);
        apb(0, PA_STAT, 0);
        chk("stat after reset", r, 0);
        apb(0, 8'hF0, 0);
        chk("unmapped error", e, 1);
        // Random core traffic with nothing armed
        repeat (40) begin
            @(posedge clock_i);
            {fetch_addr_i, dacc_addr_i, dacc_data_i} <= {xs(), xs(), xs()};
            {fetch_i, pipe_adv_i, instr_done_i, dacc_i, dacc_ctl_i} <= s[5:0];
        end
        @(posedge clock_i);
        {fetch_i, pipe_adv_i, instr_done_i, dacc_i} <= 4'h0;
        chk("no spurious halt", halted_ack_out_o, 0);
        halt_request_in_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        chk("ack before done", halted_ack_out_o, 0);
        step(1);
        repeat (20) @(posedge clock_i);
        chk("ack on request", halted_ack_out_o, 1);
        apb(0, PA_STAT, 0);
        chk("stat halted", r[2], 1);
        halt_request_in_i <= 1'b0;
        resume();
        sw(SC_CTRL, 32'h1);
        step(1);
        repeat (4) @(posedge clock_i);
        chk("ack on ctrl halt", halted_ack_out_o, 1);
        resume();
        for (int i = 0; i < 2; i++) begin
            fire(1'b1, i == 0, 32'h0);
            chk("tag halt", halted_ack_out_o, i);
        end
        resume();
        for (int i = 0; i < 4; i++) begin
            b = SC_BP_BASE + (i[0] ? 8'h20 : 8'h00);
            v = xs();
            m = xs() & 32'h0000_0FF0;
            x = i[1] ? v ^ (xs() & m) : xs();
            sw(b, v);
            sw(b + 8'h4, m);
            sw(b + 8'hC, 32'hFFFF_FFFF);
            sw(b + 8'h10, 32'h303);
            fire(1'b0, 1'b0, x);
            chk("instr bp", halted_ack_out_o, hit(v, m, x));
            if (halted_ack_out_o === 1'b1) resume();
            sw(b + 8'h10, 32'h0);
        end
        v = xs();
        sw(8'h44, 32'hFFFF_FFFF);
        sw(8'h48, v);
        sw(8'h4C, 32'h0);
        sw(8'h50, 32'h21);
        for (int c = 1; c < 3; c++) begin
            @(posedge clock_i);
            {dacc_i, dacc_data_i, dacc_ctl_i} <= {1'b1, v, 2'(c)};
            @(posedge clock_i);
            dacc_i <= 1'b0;
            step(1);
            repeat (4) @(posedge clock_i);
            chk("data bp", halted_ack_out_o, c == 2);
        end
        resume();
        apb(1, PA_IRQ_STAT, 32'h7);
        apb(1, PA_IRQ_MASK, 32'h1);
        sw(SC_TO_CORE, v);
        chk("irq on rx", irq_o, 1);
        apb(0, PA_DCC, 0);
        chk("rx word", r, v);
        apb(1, PA_IRQ_STAT, 32'h1);
        apb(1, PA_DCC, ~v);
        apb(1, PA_DCC, v);
        chk("dcc full refused", e, 1);
        u_dbh_probe.access(1'b0, SC_FROM_CORE, 32'h0, q);
        u_dbh_probe.access(1'b0, SC_STAT, 32'h0, q);
        chk("tx word", q[40:9], ~v);
        apb(0, PA_IRQ_STAT, 0);
        chk("irq status", r, 32'h2);
        chk("masked irq", irq_o, 0);
        wrap_up();
    end
endmodule
`default_nettype wire
